// ===== gph_pad_model.sv
// Board-side model of the pads: external drivers, pulls and floating lines.
// Assumes the external driver wins; a floating line with no pull toggles.
`timescale 1ns/1ps
module gph_pad_model (
   input  wire logic        sys_clk,
   input  wire logic [15:0] pad_out, pad_oe, pad_pu, pad_pd, ext_val, ext_en,
   output logic      [15:0] pad_in
);
   logic [15:0] last_q;
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         pad_in[i] = ext_en[i] ? ext_val[i] : pad_oe[i] ? pad_out[i] :
                     pad_pu[i] ? 1'b1 : pad_pd[i] ? 1'b0 : ~last_q[i];
      end
   end
   always_ff @(posedge sys_clk) last_q <= pad_in;
endmodule // gph_pad_model

// ===== gph_pkg.sv
// Package for the general purpose IO port with pad hold.
// Assumes a single 100 MHz clock domain and plain control ports.
package gph_pkg;
   // ****************************************
   // Sizes
   // ****************************************
   localparam int unsigned NUM_PINS     = 16;
   localparam int unsigned NUM_ALT      = 4;
   localparam int unsigned DAC_WIDTH    = 8;
   // ****************************************
   // Pin function select codes
   // ****************************************
   typedef enum logic [2:0] {
      GPH_FN_GPIO = 3'h0,
      GPH_FN_HOST = 3'h1,
      GPH_FN_UART = 3'h2,
      GPH_FN_SER  = 3'h3,
      GPH_FN_COEX = 3'h4
   } gph_func_e;
   // ****************************************
   // Pull select codes
   // ****************************************
   typedef enum logic [1:0] {
      GPH_PULL_NONE = 2'h0,
      GPH_PULL_UP   = 2'h1,
      GPH_PULL_DOWN = 2'h2
   } gph_pull_e;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [NUM_PINS-1:0]  RST_PIN_LEVEL = 16'h0000;
   localparam logic [DAC_WIDTH-1:0] RST_DAC_ACC   = 8'h00;
endpackage : gph_pkg

// ===== gph_port.sv
// General purpose IO port with per-pin function, pull, interrupt and pad hold.
// Assumes pad inputs synchronous to sys_clk; an outside pad cell resolves the wire.
`timescale 1ns/1ps
module gph_port
   import gph_pkg::*;
#(
   parameter int unsigned PINS = gph_pkg::NUM_PINS
) (
   input  wire logic                          sys_clk,
   input  wire logic                          arst_n,
   // Per-pin configuration, plus the shared DAC duty
   input  wire gph_pkg::gph_func_e            pin_func   [PINS],
   input  wire gph_pkg::gph_pull_e            pin_pull   [PINS],
   input  wire logic [PINS-1:0]               out_en_cfg,
   input  wire logic [PINS-1:0]               open_drain,
   input  wire logic [PINS-1:0]               src_dac,
   input  wire logic [PINS-1:0]               out_val,
   input  wire logic [gph_pkg::DAC_WIDTH-1:0] dac_duty,
   // Interrupt setup
   input  wire logic [PINS-1:0]               irq_en,
   input  wire logic [PINS-1:0]               irq_edge,
   input  wire logic [PINS-1:0]               irq_high,
   input  wire logic [PINS-1:0]               irq_clr,
   input  wire logic [PINS-1:0]               wake_en,
   input  wire logic [PINS-1:0]               wake_high,
   // Alternate function sources
   input  wire logic [PINS-1:0]               alt_out    [gph_pkg::NUM_ALT],
   input  wire logic [PINS-1:0]               alt_oe     [gph_pkg::NUM_ALT],
   // Hold control
   input  wire logic                          hold_req,
   input  wire logic                          keeper_en,
   // Pads
   input  wire logic [PINS-1:0]               pad_in,
   output logic      [PINS-1:0]               pad_out,
   output logic      [PINS-1:0]               pad_oe,
   output logic      [PINS-1:0]               pad_pu,
   output logic      [PINS-1:0]               pad_pd,
   // Status
   output logic      [PINS-1:0]               pin_level,
   output logic      [PINS-1:0]               alt_in,
   output logic      [PINS-1:0]               irq_status,
   output logic                               cpu_irq,
   output logic                               wake_irq,
   output logic                               hold_active
);

   // ****************************************
   // State
   // ****************************************
   logic [PINS-1:0] level_q;
   logic [PINS-1:0] level_d;
   logic [PINS-1:0] stat_q;
   logic [PINS-1:0] stat_d;
   logic [PINS-1:0] out_q;
   logic [PINS-1:0] out_d;
   logic [PINS-1:0] oe_q;
   logic [PINS-1:0] oe_d;
   logic [PINS-1:0] pu_q;
   logic [PINS-1:0] pu_d;
   logic [PINS-1:0] pd_q;
   logic [PINS-1:0] pd_d;
   logic [PINS-1:0] last_q;
   logic [PINS-1:0] last_d;
   logic            hold_q;
   logic            hold_d;
   logic            wake_q;
   logic            wake_d;
   logic            armed_q;
   logic            armed_d;
   logic            dac_bit;
   logic [PINS-1:0] nxt_out;
   logic [PINS-1:0] nxt_oe;
   logic [PINS-1:0] nxt_pu;
   logic [PINS-1:0] nxt_pd;
   logic [PINS-1:0] raw_hit;
   logic [PINS-1:0] wake_hit;

   gph_sigma_delta #(
      .WIDTH   (DAC_WIDTH)
   ) u_dac (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .duty    (dac_duty),
      .pdm_out (dac_bit)
   );

   // ****************************************
   // Per-pin drive and event logic
   // ****************************************
   generate
      for (genvar i = 0; i < PINS; i++) begin : g_pin
         logic src_val;
         logic en_val;
         logic lvl_now;
         always_comb begin
            src_val = src_dac[i] ? dac_bit : out_val[i];
            en_val  = out_en_cfg[i];
            unique case (pin_func[i])
               GPH_FN_GPIO: ;
               GPH_FN_HOST: begin
                  src_val = alt_out[0][i];
                  en_val  = alt_oe[0][i];
               end
               GPH_FN_UART: begin
                  src_val = alt_out[1][i];
                  en_val  = alt_oe[1][i];
               end
               GPH_FN_SER: begin
                  src_val = alt_out[2][i];
                  en_val  = alt_oe[2][i];
               end
               GPH_FN_COEX: begin
                  src_val = alt_out[3][i];
                  en_val  = alt_oe[3][i];
               end
               default: en_val = 1'b0;
            endcase
            // Open drain only pulls low; high level released
            if (open_drain[i]) begin
               nxt_out[i] = 1'b0;
               nxt_oe[i]  = en_val & ~src_val;
            end else begin
               nxt_out[i] = src_val;
               nxt_oe[i]  = en_val;
            end
            nxt_pu[i]   = (pin_pull[i] == GPH_PULL_UP);
            nxt_pd[i]   = (pin_pull[i] == GPH_PULL_DOWN);
            lvl_now     = pad_in[i] == irq_high[i];
            // Edge mode fires on transition into active level
            // No edge in first cycle after reset; prior level unknown
            raw_hit[i]  = irq_en[i] & ~nxt_oe[i] & lvl_now &
                          (~irq_edge[i] | (armed_q & (level_q[i] != pad_in[i])));
            wake_hit[i] = wake_en[i] & ~nxt_oe[i] & (pad_in[i] == wake_high[i]);
         end
      end
   endgenerate

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      level_d = pad_in;
      // Set wins over clear
      stat_d  = (stat_q & ~irq_clr) | raw_hit;
      wake_d  = |wake_hit;
      hold_d  = hold_req;
      armed_d = 1'b1;
      // Keep last driven output level (out_q) for keeper while undriven
      last_d  = (last_q & ~oe_q) | (out_q & oe_q);
      if (hold_req) begin
         out_d = out_q;
         oe_d  = '0;
         pu_d  = pu_q;
         pd_d  = pd_q;
         if (keeper_en) begin
            pu_d = last_q;
            pd_d = ~last_q;
         end
      end else begin
         // Drive registered once; no intermediate glitch on release
         out_d = nxt_out;
         oe_d  = nxt_oe;
         pu_d  = nxt_pu;
         pd_d  = nxt_pd;
         if (keeper_en) begin
            pu_d = nxt_pu | (~nxt_oe & ~nxt_pd & last_q);
            pd_d = nxt_pd | (~nxt_oe & ~nxt_pu & ~last_q);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         level_q <= PINS'(RST_PIN_LEVEL);
         stat_q  <= '0;
         out_q   <= '0;
         oe_q    <= '0;
         pu_q    <= '0;
         pd_q    <= '0;
         last_q  <= '0;
         hold_q  <= 1'b0;
         armed_q <= 1'b0;
         wake_q  <= 1'b0;
      end else begin
         level_q <= level_d;
         stat_q  <= stat_d;
         out_q   <= out_d;
         oe_q    <= oe_d;
         pu_q    <= pu_d;
         pd_q    <= pd_d;
         last_q  <= last_d;
         hold_q  <= hold_d;
         armed_q <= armed_d;
         wake_q  <= wake_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign pad_out     = out_q;
   assign pad_oe      = oe_q;
   assign pad_pu      = pu_q;
   assign pad_pd      = pd_q;
   assign pin_level   = level_q;
   assign alt_in      = level_q;
   assign irq_status  = stat_q;
   assign cpu_irq     = |stat_q;
   assign wake_irq    = wake_q;
   assign hold_active = hold_q;

endmodule // gph_port

// ===== gph_port_sva.sv
// Checker for the IO port, bound to every instance of the port.
// Assumes pin 0 drive, edge and wake checks run only while pin 0 is set to plain GPIO.
`timescale 1ns/1ps
module gph_port_sva #(
   parameter int unsigned PINS = 16
) (
   input wire logic               sys_clk, arst_n, hold_req, cpu_irq, wake_irq, hold_active,
   input wire gph_pkg::gph_func_e pin_func [PINS],
   input wire logic [PINS-1:0]    out_en_cfg, open_drain, src_dac, out_val, irq_en, irq_edge,
   input wire logic [PINS-1:0]    irq_high, irq_clr, wake_en, wake_high, pad_in, pad_out,
   input wire logic [PINS-1:0]    pad_oe, pin_level, irq_status
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   wire logic gp0 = pin_func[0] == gph_pkg::GPH_FN_GPIO && !out_en_cfg[0];
   wire logic dr0 = pin_func[0] == gph_pkg::GPH_FN_GPIO && out_en_cfg[0] && !hold_req
                    && !src_dac[0];
   sequence s_hold2; hold_req ##1 hold_req; endsequence
   property p_oe_off; hold_req |=> pad_oe == '0; endproperty
   a_oe_off: assert property (p_oe_off) else $error("pad enabled in hold");
   property p_frozen; s_hold2 |-> $stable(pad_out); endproperty
   a_frozen: assert property (p_frozen) else $error("pad value moved in hold");
   property p_hact; $changed(hold_req) |=> hold_active == $past(hold_req); endproperty
   a_hact: assert property (p_hact) else $error("hold flag late");
   property p_drive; dr0 && !open_drain[0] |=> pad_oe[0] && pad_out[0] == $past(out_val[0]);
   endproperty
   a_drive: assert property (p_drive) else $error("push-pull drive wrong");
   property p_od; dr0 && open_drain[0] |=> pad_oe[0] != $past(out_val[0]); endproperty
   a_od: assert property (p_od) else $error("open-drain enable wrong");
   property p_lvl; 1 |=> pin_level == $past(pad_in); endproperty
   a_lvl: assert property (p_lvl) else $error("sampled level wrong");
   property p_edge; gp0 && irq_en[0] && irq_edge[0] && irq_high[0] && pad_in[0]
      && !pin_level[0] && $past(arst_n) |=> irq_status[0]; endproperty
   a_edge: assert property (p_edge) else $error("edge not caught");
   property p_sticky; irq_status[0] && !irq_clr[0] |=> irq_status[0]; endproperty
   a_sticky: assert property (p_sticky) else $error("status lost");
   property p_cpu; (|irq_status) |-> ##[0:1] cpu_irq; endproperty
   a_cpu: assert property (p_cpu) else $error("cpu interrupt missing");
   property p_wake; gp0 && wake_en[0] && wake_high[0] && pad_in[0] |-> ##[1:2] wake_irq;
   endproperty
   a_wake: assert property (p_wake) else $error("wake missing");
endmodule // gph_port_sva
bind gph_port gph_port_sva #(.PINS(PINS)) i_gph_port_sva (.sys_clk, .arst_n, .hold_req,
   .cpu_irq, .wake_irq, .hold_active, .pin_func, .out_en_cfg, .open_drain, .src_dac,
   .out_val, .irq_en, .irq_edge, .irq_high, .irq_clr, .wake_en, .wake_high, .pad_in,
   .pad_out, .pad_oe, .pin_level, .irq_status);

// ===== gph_port_tb.sv
// Self-checking bench for the IO port with the board model on its pads.
// Assumes one 100 MHz clock; inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module gph_port_tb;
   import gph_pkg::*;
   logic sys_clk = 0, arst_n = 0, hold_req = 0, keeper_en = 0, cirq, wirq, hact;
   logic [15:0] oe_cfg = 0, od = 0, dac = 0, oval = 0, ien = 0, iedge = 0, ihigh = 0;
   logic [15:0] iclr = 0, wen = 0, whigh = 0, ext_v = 0, ext_e = 16'hffff, aout [4], aoe [4];
   logic [15:0] pin, pout, poe, ppu, ppd, lvl, ist, ain;
   logic [7:0]  duty = 0;
   gph_func_e   func [16];
   gph_pull_e   pull [16];
   int          n_fail = 0, total_checks = 0, ones;
   always #5 sys_clk = ~sys_clk;
   gph_port i_gph_port (.sys_clk, .arst_n, .pin_func(func), .pin_pull(pull),
      .out_en_cfg(oe_cfg), .open_drain(od), .src_dac(dac), .out_val(oval), .dac_duty(duty),
      .irq_en(ien), .irq_edge(iedge), .irq_high(ihigh), .irq_clr(iclr), .wake_en(wen),
      .wake_high(whigh), .alt_out(aout), .alt_oe(aoe), .hold_req, .keeper_en, .pad_in(pin),
      .pad_out(pout), .pad_oe(poe), .pad_pu(ppu), .pad_pd(ppd), .pin_level(lvl),
      .alt_in(ain), .irq_status(ist), .cpu_irq(cirq), .wake_irq(wirq), .hold_active(hact));
   gph_pad_model i_gph_pad_model (.sys_clk, .pad_out(pout), .pad_oe(poe), .pad_pu(ppu),
      .pad_pd(ppd), .ext_val(ext_v), .ext_en(ext_e), .pad_in(pin));
   task automatic step(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (n_fail == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #50000;
      n_fail++;
      finish_test();
   end
   initial begin
      foreach (func[i]) func[i] = GPH_FN_GPIO;
      foreach (pull[i]) pull[i] = GPH_PULL_NONE;
      foreach (aout[i]) aout[i] = 16'h1111 << i;
      foreach (aoe[i]) aoe[i] = 16'hff00 >> (4 * i);
      repeat (12) @(posedge sys_clk);
      #1 arst_n = 1;
      ext_e = 0; oe_cfg = 16'hffff; oval = 16'ha5c3; step(2);
      chk(poe, 16'hffff);
      chk(pout, 16'ha5c3);
      chk(lvl, 16'ha5c3);
      chk(ain, 16'ha5c3);
      od = 16'hffff; step(1);
      chk(poe, 16'h5a3c);
      chk(pout & poe, 16'h0000);
      od = 0;
      for (int f = 1; f < 6; f++) begin
         foreach (func[i]) func[i] = gph_func_e'(f);
         step(1);
         chk(poe, f < 5 ? aoe[f-1] : 16'h0000);
         if (f < 5) chk(pout & poe, aout[f-1] & aoe[f-1]);
      end
      foreach (func[i]) func[i] = GPH_FN_GPIO;
      oe_cfg = 0;
      for (int p = 0; p < 3; p++) begin
         foreach (pull[i]) pull[i] = gph_pull_e'(p);
         step(1);
         chk(ppu, {16{p == 1}});
         chk(ppd, {16{p == 2}});
      end
      foreach (pull[i]) pull[i] = GPH_PULL_NONE;
      ext_e = 16'hffff; ext_v = 16'h0002; ien = 16'h0003; iedge = 16'h0001;
      ihigh = 16'h0001; iclr = 16'hffff; step(2);
      iclr = 0; step(1);
      chk(ist, 16'h0000);
      ext_v = 16'h0001; step(2);
      chk(ist, 16'h0003);
      chk({15'h0, cirq}, 16'h0001);
      iclr = 16'h0002;
      step(1);
      chk(ist, 16'h0003);
      ext_v = 16'h0003; iclr = 16'h0003; step(1);
      iclr = 0; step(1);
      chk(ist, 16'h0000);
      ien = 0; ext_v = 0; wen = 16'h0001; whigh = 16'h0001; step(3);
      chk({15'h0, wirq}, 16'h0000);
      ext_v = 16'h0001; step(2);
      chk({15'h0, wirq}, 16'h0001);
      wen = 0; ext_e = 0; oe_cfg = 16'hffff; oval = 16'h3c3c; keeper_en = 1; step(2);
      hold_req = 1; oval = 16'hc3c3; step(2);
      chk(poe, 16'h0000);
      chk(pout, 16'h3c3c);
      chk(ppu, 16'h3c3c);
      chk(ppd, 16'hc3c3);
      chk({15'h0, hact}, 16'h0001);
      hold_req = 0; keeper_en = 0; step(1);
      chk(poe, 16'hffff);
      chk(pout, 16'hc3c3);
      dac = 16'h0001; duty = 8'h40; step(8);
      ones = 0;
      repeat (256) begin
         ones += pout[0];
         step(1);
      end
      chk(ones[15:0], 16'h0040);
      finish_test();
   end
endmodule // gph_port_tb

// ===== gph_sigma_delta.sv
// First-order sigma-delta pulse-density modulator.
// Assumes duty is held steady by the caller between updates.
`timescale 1ns/1ps
module gph_sigma_delta #(
   parameter int unsigned WIDTH = gph_pkg::DAC_WIDTH
) (
   input  wire logic             sys_clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] duty,
   output logic                  pdm_out
);
   import gph_pkg::*;

   logic [WIDTH-1:0] acc_q;
   logic [WIDTH-1:0] acc_d;
   logic             pdm_q;
   logic             pdm_d;

   always_comb begin
      logic [WIDTH:0] sum;
      sum   = {1'b0, acc_q} + {1'b0, duty};
      acc_d = sum[WIDTH-1:0];
      pdm_d = sum[WIDTH];
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_q <= WIDTH'(RST_DAC_ACC);
         pdm_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         pdm_q <= pdm_d;
      end
   end

   assign pdm_out = pdm_q;
endmodule // gph_sigma_delta
